// File: hdl/pia_phy_indirect_access.sv
// Operation
// - function 00: window reaches the extended address register
// - nonzero function: window reaches the extended data register
// - function 01: data access, extended address stays unchanged
// - function 10: address advances after every window data read or write
// - function 11: address advances after window data writes only
// - bits 13:5 of access control ignore writes and read zero
// - fifo depth field: 4, 5, 6 or 8 nibbles, resets to 01
// - force-link bit forces link control enable for the selected speed
// - power-down 01: all but management off; pll off too when disabled
// - active sleep: passive sleep plus wake pulse about every 1.4 s
// - passive sleep: management and energy detect only; wake on partner
// - auto-crossover bit enables crossover; reset value from the strap
// - manual crossover bit: zero straight, one crossed
// - pll-disable bit turns the pll off in power-down 01 while basic power-down is set
// - jabber-disable bit suppresses the jabber function
//
// Purpose: indirect extended-register access and phy control behind AXI4-Lite
// Assumes: one write and one read outstanding at most; strap and energy pins are asynchronous
// Notes:   extended data words are flip-flops indexed by the low address bits
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module pia_phy_indirect_access #(
    parameter int unsigned EXT_DEPTH_LOG2 = 5,
    parameter int unsigned NLP_PERIOD     = pia_pkg::NLP_INTERVAL_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        strap_auto_mdix,
    input  wire logic        energy_detect,
    input  wire logic        basic_speed_100,
    input  wire logic        basic_power_down,
    output logic [4:0]       target_device_select,
    output logic [3:0]       tx_fifo_depth_nibbles,
    output logic             link_control_force_enable_10,
    output logic             link_control_force_enable_100,
    output logic             core_power_down,
    output logic             energy_detect_enable,
    output logic             pll_enable,
    output logic             ref_clock_select,
    output logic             nlp_wake_pulse,
    output logic             auto_mdix_enable,
    output logic             manual_mdix,
    output logic             jabber_enable
);

    localparam int unsigned EXT_DEPTH = 1 << EXT_DEPTH_LOG2;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [15:0] merge_bytes(input logic [15:0] old_value,
                                                input logic [31:0] wdata,
                                                input logic [3:0]  wstrb,
                                                input logic [15:0] wmask);
        logic [15:0] merged;
        merged = old_value;
        if (wstrb[0]) begin
            merged[7:0] = wdata[7:0];
        end
        if (wstrb[1]) begin
            merged[15:8] = wdata[15:8];
        end
        return (merged & wmask) | (old_value & ~wmask);
    endfunction : merge_bytes

    function automatic logic [3:0] fifo_nibbles(input logic [1:0] code);
        case (code)
            2'h0:    return 4'h4;
            2'h1:    return 4'h5;
            2'h2:    return 4'h6;
            default: return 4'h8;
        endcase
    endfunction : fifo_nibbles

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a change counts once the second and third stages agree

    logic [2:0] strap_sync;
    logic [2:0] energy_sync;
    logic       strap_level;
    logic       energy_level;
    logic       next_strap_level;
    logic       next_energy_level;

    always_comb begin
        next_strap_level  = strap_level;
        next_energy_level = energy_level;
        if (strap_sync[1] == strap_sync[2]) begin
            next_strap_level = strap_sync[2];
        end
        if (energy_sync[1] == energy_sync[2]) begin
            next_energy_level = energy_sync[2];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_sync   <= 3'h0;
            energy_sync  <= 3'h0;
            strap_level  <= 1'b0;
            energy_level <= 1'b0;
        end else begin
            strap_sync   <= {strap_sync[1:0], strap_auto_mdix};
            energy_sync  <= {energy_sync[1:0], energy_detect};
            strap_level  <= next_strap_level;
            energy_level <= next_energy_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register state and bus slave

    logic [15:0] access_ctrl;
    logic [15:0] ext_addr;
    logic [15:0] ext_mem [EXT_DEPTH];
    logic [15:0] misc_ctrl;
    logic [1:0]  strap_count;
    logic        strap_done;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] nlp_count;

    logic [15:0] next_access_ctrl;
    logic [15:0] next_ext_addr;
    logic [15:0] next_ext_mem [EXT_DEPTH];
    logic [15:0] next_misc_ctrl;
    logic [1:0]  next_strap_count;
    logic        next_strap_done;
    logic        next_aw_held;
    logic        next_w_held;
    logic [7:0]  next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_rvalid;
    logic [1:0]  next_rresp;
    logic [31:0] next_rdata;
    logic [31:0] next_nlp_count;
    logic        next_nlp_pulse;

    logic [1:0]  func;
    logic [1:0]  pd_mode;
    logic        do_write;
    logic        do_read;
    logic        in_sleep;
    logic [15:0] read_word;
    logic [15:0] step;
    logic [EXT_DEPTH_LOG2-1:0] ext_index;

    assign func      = access_ctrl[pia_pkg::FUNC_LO +: 2];
    assign pd_mode   = misc_ctrl[pia_pkg::PD_LO +: 2];
    assign ext_index = ext_addr[EXT_DEPTH_LOG2-1:0];
    assign in_sleep  = (pd_mode == pia_pkg::PD_ACTIVE_SLEEP) || (pd_mode == pia_pkg::PD_PASSIVE_SLEEP);

    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !rvalid;
    assign do_write      = aw_held && w_held && !bvalid;
    assign do_read       = s_axi_arvalid && !rvalid;

    always_comb begin
        next_access_ctrl = access_ctrl;
        next_ext_addr    = ext_addr;
        next_ext_mem     = ext_mem;
        next_misc_ctrl   = misc_ctrl;
        next_strap_count = strap_count;
        next_strap_done  = strap_done;
        next_aw_held     = aw_held;
        next_w_held      = w_held;
        next_aw_addr     = aw_addr;
        next_w_data      = w_data;
        next_w_strb      = w_strb;
        next_bvalid      = bvalid;
        next_bresp       = bresp;
        next_rvalid      = rvalid;
        next_rresp       = rresp;
        next_rdata       = rdata;
        read_word        = 16'h0000;
        step             = 16'h0000;

        // strap is caught only once the synchroniser has settled after release
        // strap reset value
        if (!strap_done) begin
            if (strap_count == pia_pkg::STRAP_SETTLE_CYCLES) begin
                next_misc_ctrl[pia_pkg::AUTO_MDIX] = next_strap_level;
                next_strap_done = 1'b1;
            end else begin
                next_strap_count = strap_count + 2'h1;
            end
        end

        if (in_sleep && energy_level) begin
            next_misc_ctrl[pia_pkg::PD_LO +: 2] = pia_pkg::PD_NORMAL;
        end

        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end

        // reads are handled first so a same-cycle window write adds its step to the read's step
        if (do_read) begin
            next_rvalid = 1'b1;
            next_rresp  = pia_pkg::RESP_OKAY;
            case (s_axi_araddr)
                pia_pkg::ADDR_ACCESS_CTRL: read_word = access_ctrl & pia_pkg::ACCESS_CTRL_WMASK;
                pia_pkg::ADDR_WINDOW: begin
                    if (func == pia_pkg::FUNC_ADDRESS) begin
                        read_word = ext_addr;
                    end else begin
                        read_word = ext_mem[ext_index];
                    end
                    if (func == pia_pkg::FUNC_DATA_INC_RW) begin
                        step = 16'h0001;
                    end
                end
                pia_pkg::ADDR_MISC_CTRL: read_word = misc_ctrl & pia_pkg::MISC_CTRL_WMASK;
                default: next_rresp = pia_pkg::RESP_SLVERR;
            endcase
            next_rdata = {16'h0000, read_word};
        end

        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = pia_pkg::RESP_OKAY;
            case (aw_addr)
                pia_pkg::ADDR_ACCESS_CTRL: begin
                    next_access_ctrl = merge_bytes(access_ctrl, w_data, w_strb,
                                                   pia_pkg::ACCESS_CTRL_WMASK);
                end
                pia_pkg::ADDR_WINDOW: begin
                    if (func == pia_pkg::FUNC_ADDRESS) begin
                        next_ext_addr = merge_bytes(ext_addr, w_data, w_strb, 16'hffff);
                        step = 16'h0000;
                    end else begin
                        next_ext_mem[ext_index] = merge_bytes(ext_mem[ext_index], w_data,
                                                              w_strb, 16'hffff);
                        if (func != pia_pkg::FUNC_DATA_HOLD) begin
                            step = step + 16'h0001;
                        end
                    end
                end
                pia_pkg::ADDR_MISC_CTRL: begin
                    next_misc_ctrl = merge_bytes(misc_ctrl, w_data, w_strb,
                                                 pia_pkg::MISC_CTRL_WMASK);
                end
                default: next_bresp = pia_pkg::RESP_SLVERR;
            endcase
        end

        next_ext_addr = next_ext_addr + step;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            access_ctrl <= pia_pkg::ACCESS_CTRL_RESET;
            ext_addr    <= pia_pkg::WINDOW_RESET;
            ext_mem     <= '{default: 16'h0000};
            misc_ctrl   <= pia_pkg::MISC_CTRL_RESET;
            strap_count <= 2'h0;
            strap_done  <= 1'b0;
            aw_held     <= 1'b0;
            w_held      <= 1'b0;
            aw_addr     <= 8'h00;
            w_data      <= 32'h0000_0000;
            w_strb      <= 4'h0;
            bvalid      <= 1'b0;
            bresp       <= 2'h0;
            rvalid      <= 1'b0;
            rresp       <= 2'h0;
            rdata       <= 32'h0000_0000;
        end else begin
            access_ctrl <= next_access_ctrl;
            ext_addr    <= next_ext_addr;
            ext_mem     <= next_ext_mem;
            misc_ctrl   <= next_misc_ctrl;
            strap_count <= next_strap_count;
            strap_done  <= next_strap_done;
            aw_held     <= next_aw_held;
            w_held      <= next_w_held;
            aw_addr     <= next_aw_addr;
            w_data      <= next_w_data;
            w_strb      <= next_w_strb;
            bvalid      <= next_bvalid;
            bresp       <= next_bresp;
            rvalid      <= next_rvalid;
            rresp       <= next_rresp;
            rdata       <= next_rdata;
        end
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp  = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp  = rresp;
    assign s_axi_rdata  = rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // active-sleep wake pulse timer

    logic nlp_pulse;

    always_comb begin
        next_nlp_count = 32'h0000_0000;
        next_nlp_pulse = 1'b0;
        if (pd_mode == pia_pkg::PD_ACTIVE_SLEEP && basic_power_down) begin
            if (nlp_count == NLP_PERIOD - 1) begin
                next_nlp_pulse = 1'b1;
            end else begin
                next_nlp_count = nlp_count + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nlp_count <= 32'h0000_0000;
            nlp_pulse <= 1'b0;
        end else begin
            nlp_count <= next_nlp_count;
            nlp_pulse <= next_nlp_pulse;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control outputs, decoded straight from register bits

    assign target_device_select = access_ctrl[pia_pkg::DEV_LO +: 5];
    assign tx_fifo_depth_nibbles = fifo_nibbles(misc_ctrl[pia_pkg::FIFO_LO +: 2]);
    assign link_control_force_enable_10  = misc_ctrl[pia_pkg::FORCE_LINK] && !basic_speed_100;
    assign link_control_force_enable_100 = misc_ctrl[pia_pkg::FORCE_LINK] && basic_speed_100;
    // modes need basic control bit 11 as well
    assign core_power_down      = (pd_mode != pia_pkg::PD_NORMAL) && basic_power_down;
    assign energy_detect_enable = !core_power_down || in_sleep;
    // pll stops in general power-down / pll disable
    assign pll_enable       = !(misc_ctrl[pia_pkg::PLL_OFF] &&
                                (pd_mode == pia_pkg::PD_GENERAL) && basic_power_down);
    assign ref_clock_select = !pll_enable;
    assign nlp_wake_pulse   = nlp_pulse;
    assign auto_mdix_enable = misc_ctrl[pia_pkg::AUTO_MDIX];
    assign manual_mdix      = misc_ctrl[pia_pkg::MANUAL_MDIX];
    assign jabber_enable    = !misc_ctrl[pia_pkg::JABBER_OFF];

endmodule : pia_phy_indirect_access

`default_nettype wire

// File: pkg/pia_pkg.sv
// Purpose: shared constants for the indirect extended-register access and phy control block
// Assumes: 200 MHz clock, AXI4-Lite with 32-bit data, registers in the low 16 bits of a word
// Notes:   printed offsets are word indices; the byte address is four times the index
package pia_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLK_FREQ_KHZ        = 200_000;
    localparam int unsigned NLP_INTERVAL_MS     = 1400;
    localparam int unsigned NLP_INTERVAL_CYCLES = NLP_INTERVAL_MS * CLK_FREQ_KHZ;
    localparam logic [1:0]  STRAP_SETTLE_CYCLES = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // register indices and byte addresses
    localparam logic [5:0] IDX_ACCESS_CTRL = 6'h0d;
    localparam logic [5:0] IDX_WINDOW      = 6'h0e;
    localparam logic [5:0] IDX_MISC_CTRL   = 6'h10;
    localparam logic [7:0] ADDR_ACCESS_CTRL = {IDX_ACCESS_CTRL, 2'b00};
    localparam logic [7:0] ADDR_WINDOW      = {IDX_WINDOW, 2'b00};
    localparam logic [7:0] ADDR_MISC_CTRL   = {IDX_MISC_CTRL, 2'b00};

    ////////////////////////////////////////////////////////////////////////////////
    // ext_access_control fields
    localparam int unsigned FUNC_LO = 14;
    localparam int unsigned DEV_LO  = 0;
    localparam logic [15:0] ACCESS_CTRL_RESET = 16'h0000;
    localparam logic [15:0] ACCESS_CTRL_WMASK = 16'hc01f;
    localparam logic [1:0]  FUNC_ADDRESS      = 2'h0;
    localparam logic [1:0]  FUNC_DATA_HOLD    = 2'h1;
    localparam logic [1:0]  FUNC_DATA_INC_RW  = 2'h2;
    localparam logic [1:0]  FUNC_DATA_INC_WR  = 2'h3;
    localparam logic [15:0] WINDOW_RESET      = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // phy_misc_control fields
    localparam int unsigned FIFO_LO       = 14;
    localparam int unsigned FORCE_LINK    = 10;
    localparam int unsigned PD_LO         = 8;
    localparam int unsigned AUTO_MDIX     = 6;
    localparam int unsigned MANUAL_MDIX   = 5;
    localparam int unsigned PLL_OFF       = 4;
    localparam int unsigned JABBER_OFF    = 0;
    localparam logic [15:0] MISC_CTRL_RESET = 16'h4000;
    localparam logic [15:0] MISC_CTRL_WMASK = 16'hc7f1;
    localparam logic [1:0]  PD_NORMAL        = 2'h0;
    localparam logic [1:0]  PD_GENERAL       = 2'h1;
    localparam logic [1:0]  PD_ACTIVE_SLEEP  = 2'h2;
    localparam logic [1:0]  PD_PASSIVE_SLEEP = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pia_pkg

// File: verification/pia_host_model.sv
// Purpose: AXI4-Lite host model
// Assumes: one transfer at a time, full strobes
// Notes:   the bench watchdog ends a hang
`timescale 1ns/100ps
`default_nettype none
module pia_host_model (
    input  wire logic        clk,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        wstrb = 4'hf;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            aw_ok = aw_ok | awready;
            w_ok = w_ok | wready;
            awvalid <= !aw_ok;
            wvalid  <= !w_ok;
        end
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : pia_host_model
`default_nettype wire

// File: verification/pia_phy_indirect_access_assertions.sv
// Purpose: port checker
// Assumes: one clock, async reset
// Notes:   outputs are decodes of registers
`timescale 1ns/100ps
`default_nettype none
module pia_phy_indirect_access_assertions (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        s_axi_rvalid,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic        basic_speed_100,
    input  wire logic        basic_power_down,
    input  wire logic [3:0]  tx_fifo_depth_nibbles,
    input  wire logic        link_control_force_enable_10,
    input  wire logic        link_control_force_enable_100,
    input  wire logic        core_power_down,
    input  wire logic        energy_detect_enable,
    input  wire logic        pll_enable,
    input  wire logic        ref_clock_select,
    input  wire logic        nlp_wake_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_fifo_legal: assert property (tx_fifo_depth_nibbles inside {4'h4, 4'h5, 4'h6, 4'h8})
        else $error("fifo depth out of range");
    a_force_excl: assert property (!(link_control_force_enable_10 && link_control_force_enable_100))
        else $error("both link enables forced");
    a_force_speed: assert property (link_control_force_enable_100 |-> basic_speed_100)
        else $error("100M forced without 100M speed");
    a_force_slow: assert property (link_control_force_enable_10 |-> !basic_speed_100)
        else $error("10M forced without 10M speed");
    a_ref_clock: assert property (ref_clock_select == !pll_enable)
        else $error("reference clock select wrong");
    a_pll_off_pd: assert property (!pll_enable |-> core_power_down)
        else $error("pll off outside power-down");
    a_pd_gated: assert property (core_power_down |-> basic_power_down)
        else $error("power-down without basic control bit");
    a_pulse_once: assert property (nlp_wake_pulse |=> !nlp_wake_pulse)
        else $error("wake pulse longer than a cycle");
    a_pulse_sleep: assert property (nlp_wake_pulse |-> core_power_down && energy_detect_enable)
        else $error("wake pulse outside active sleep");
    a_edet_on: assert property (!energy_detect_enable |-> core_power_down)
        else $error("energy detect off while awake");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    c_pulse: cover property (nlp_wake_pulse);
    c_pll_off: cover property (!pll_enable);
    c_force: cover property (link_control_force_enable_100);
endmodule : pia_phy_indirect_access_assertions
bind pia_phy_indirect_access pia_phy_indirect_access_assertions chk (.*);
`default_nettype wire

// File: verification/pia_phy_indirect_access_test.sv
// Purpose: self-checking bench with a register model
// Assumes: short wake period, strap high through reset
// Notes:   extended words alias modulo 32
`timescale 1ns/100ps
`default_nettype none
module pia_phy_indirect_access_test;
    logic clk = 0, reset_n = 0, strap = 1, edet = 0, spd = 0, bpd = 0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, depth;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [4:0] dsel;
    logic l10, l100, cpd, ede, plle, refc, nlp, amdix, mmdix, jab;
    int error_cnt = 0, checks_done = 0, seed = 61, ea = 0, ac = 0, mc, n, v;
    int mem[32];
    int dt[4] = '{4, 5, 6, 8};
    always #2.5 clk = ~clk;
    pia_phy_indirect_access #(.NLP_PERIOD(20)) dut (.clk(clk), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .strap_auto_mdix(strap), .energy_detect(edet), .basic_speed_100(spd),
        .basic_power_down(bpd), .target_device_select(dsel), .tx_fifo_depth_nibbles(depth),
        .link_control_force_enable_10(l10), .link_control_force_enable_100(l100),
        .core_power_down(cpd), .energy_detect_enable(ede), .pll_enable(plle),
        .ref_clock_select(refc), .nlp_wake_pulse(nlp), .auto_mdix_enable(amdix),
        .manual_mdix(mmdix), .jabber_enable(jab));
    pia_host_model host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [1:0] r;
        host.wr(a, {16'h0000, d}, r);
        case (a)
            8'h34: ac = d & 16'hc01f;
            8'h38: if (ac[15:14] == 0) ea = d;
                else begin
                    mem[ea % 32] = d;
                    if (ac[15:14] >= 2) ea = (ea + 1) & 16'hffff;
                end
            8'h40: mc = d & 16'hc7f1;
            default: ;
        endcase
        cmp(r, (a inside {8'h34, 8'h38, 8'h40}) ? 2'h0 : 2'h2);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic [31:0] d;
        logic [1:0] r;
        int e;
        e = 0;
        host.rd(a, d, r);
        case (a)
            8'h34: e = ac;
            8'h38: begin
                e = (ac[15:14] == 0) ? ea : mem[ea % 32];
                if (ac[15:14] == 2) ea = (ea + 1) & 16'hffff;
            end
            8'h40: e = mc;
            default: ;
        endcase
        cmp(d, e);
        cmp(r, (a inside {8'h34, 8'h38, 8'h40}) ? 2'h0 : 2'h2);
    endtask : rd
    task automatic test_done;
        if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #50000;
        error_cnt++;
        test_done;
    end
    initial begin
        foreach (mem[i]) mem[i] = 0;
        mc = 16'h4040;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        rd(8'h34);
        rd(8'h38);
        rd(8'h40);
        wr(8'h34, 16'hffff);
        rd(8'h34);
        wr(8'h34, 16'h001f);
        cmp(dsel, 5'h1f);
        for (int f = 0; f < 4; f++) begin
            wr(8'h34, (f << 14) | 16'h001f);
            wr(8'h38, 16'h1230 + f);
            rd(8'h38);
            rd(8'h38);
        end
        for (int i = 0; i < 60; i++) begin
            v = $random(seed);
            case (v[1:0])
                0: wr(8'h34, {v[17:16], 14'h001f});
                1: wr(8'h38, v[31:16]);
                default: rd(8'h38);
            endcase
        end
        wr(8'h34, 16'h001f);
        rd(8'h38);
        wr(8'h3c, 16'h5555);
        rd(8'h44);
        bpd <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            v = $random(seed);
            spd <= v[20];
            wr(8'h40, {i[1:0], v[13:10], i[3:2], v[7:0]});
            @(negedge clk);
            cmp(depth, dt[i & 3]);
            cmp({l100, l10}, {mc[10] & spd, mc[10] & !spd});
            cmp(cpd, i[3:2] != 0);
            cmp({plle, refc}, {!(mc[4] && i[3:2] == 1), mc[4] && i[3:2] == 1});
            cmp(ede, i[3:2] != 1);
            cmp({amdix, mmdix, jab}, {mc[6], mc[5], !mc[0]});
            rd(8'h40);
        end
        wr(8'h40, 16'h0200);
        n = 0;
        do @(negedge clk); while (!nlp);
        do begin
            @(negedge clk);
            n++;
        end while (!nlp && n < 100);
        cmp(n, 20);
        wr(8'h40, 16'h0300);
        cmp(ede, 1'b1);
        edet <= 1'b1;
        repeat (8) @(posedge clk);
        mc = mc & 16'hfcff;
        cmp(cpd, 1'b0);
        rd(8'h40);
        edet <= 1'b0;
        test_done;
    end
endmodule : pia_phy_indirect_access_test
`default_nettype wire
